// file: rtl/xcl_ext_ctrl.sv
`timescale 1ns/1ps
`include "xcl_cfg.svh"
// Behaviour
// RQ1: writing 01xx10xx to the first key unlocks the extended register set
// RQ2: writing 101xxxxx to the second key unlocks system control and extension registers
// RQ3: after reset, system control registers are locked for reads and writes
// RQ4: unlock lasts while the key holds; changing a significant key bit relocks
// RQ5: reserved bits are written as zero; reads of them return zero here
// RQ6: bits 1-0 pick alternate refresh count, effective only when bit 2 set
// RQ7: top-of-memory bit forces processor and refresh accesses to top region
// RQ8: enhanced-color bit selects 4-bit or wide shift register modes
// RQ9: bus-width bit selects 8-bit bus when clear, 16-bit when set
// RQ10: transfer position applies for VRAM only when compatibility bit 4 set
// RQ11: interlace retrace start gives even/odd frame offset in interlaced mode
// RQ12: enhanced-access bit enables enhanced-mode register access
// RQ13: signal select turns memory-id pins into strobe or grant/request
// RQ14: wait-state bit inserts one wait state when set; reset value is one
// RQ15: fast-write bit enables write posting; clear after reset
// RQ16: decode wait field 00/01/10/11 gives 0/1/3/2 wait states
// RQ17: read wait field same encoding; on ISA only 00 enables zero-wait signal
// RQ18: pixel clock field used only when clock select is 11, sent by strobe
// RQ19: edge-mode bit selects rising only or both video clock edges
// RQ20: dac select extension bit ignored unless dac control bits 3-2 are zero
// RQ21: screen width bit eight ignored unless control 2 bits 5-4 are zero
// RQ22: translate bit moves port X2E8H to address XOR 3A0H
// RQ23: locked registers ignore writes and read back as zero
module xcl_ext_ctrl
  import xcl_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // index/data register port
  input  wire xcl_req_s    host_req,
  output logic [7:0]       host_rdata,
  output logic             host_rvalid,
  // context from neighbouring registers
  input  wire logic        isa_bus_mode,
  input  wire logic        compat_xfer_enable,
  input  wire logic        vram_config,
  input  wire logic [1:0]  misc_clock_select,
  input  wire logic [1:0]  dac_ctrl_select,
  input  wire logic        dac_ctrl_strobe_mode,
  input  wire logic [1:0]  sys_ctrl2_width,
  input  wire logic        bus_grant_in,
  // decoded controls
  output logic [1:0]       refresh_count,
  output logic             top_memory_force,
  output logic             wide_color_shift_mode,
  output logic             high_speed_font_write,
  output logic             wide_memory_select_signal,
  output logic             xfer_position_valid,
  output logic [7:0]       xfer_position,
  output logic [7:0]       interlace_offset,
  output logic             interlace_enable,
  output logic             enhanced_access_enable,
  output logic             memory_id_pin_a,
  output logic             memory_id_pin_b,
  output logic             read_strobe_out,
  output logic             bus_request_out,
  output logic             bus_grant_seen,
  output logic [1:0]       wait_states,
  output logic             write_posting_enable,
  output logic [1:0]       decode_wait_count,
  output logic [1:0]       read_wait_count,
  output logic             zero_wait_signal,
  output logic [3:0]       pixel_clock_select,
  output logic             clock_strobe_write,
  output logic             video_clock_edge_mode,
  output logic             dac_select_ext_bit,
  output logic             screen_width_bit_eight,
  output logic             sixteen_bit_color_enable,
  output logic [15:0]      extended_port_addr,
  output logic             horizontal_counter_double
);

  //////////////////////////////////////////////////////////////////////////////

  // the field encodes 3 at 10 and 2 at 11, so swap bit 0 when bit 1 is set
  function automatic logic [1:0] wait_decode(input logic [1:0] f);
    wait_decode = {f[1], f[0] ^ f[1]};
  endfunction

  function automatic logic key_match(input logic [7:0] v, input logic [7:0] m,
                                     input logic [7:0] k);
    key_match = ((v & m) == k);
  endfunction

  logic [7:0]  key1_reg;
  logic [7:0]  key2_reg;
  logic [7:0]  misc1_reg;
  logic [7:0]  xfer_pos_reg;
  logic [7:0]  ilace_reg;
  logic [7:0]  syscfg_reg;
  logic [7:0]  fwflag_reg;
  logic [7:0]  pclk_reg;
  logic [7:0]  extmode_reg;
  logic        ext_unlocked;
  logic        sys_unlocked;
  xcl_syscfg_s syscfg;
  logic [7:0]  rdata_next;
  logic        pclk_written_reg;
  logic        pclk_use;
  xcl_stb_e    stb_reg;
  xcl_stb_e    stb_next;

  // unlock follows the stored key directly, so changing a masked key bit relocks at once
  assign ext_unlocked = key_match(key1_reg, `XCL_KEY1_MASK, `XCL_KEY1_VAL); // RQ1 RQ4
  assign sys_unlocked = key_match(key2_reg, `XCL_KEY2_MASK, `XCL_KEY2_VAL); // RQ2 RQ4
  assign syscfg       = xcl_syscfg_s'(syscfg_reg);
  assign pclk_use     = (misc_clock_select == `XCL_MISC_CLK_EXT);

  //////////////////////////////////////////////////////////////////////////////
  // key registers are always reachable

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key1_reg <= `XCL_RST_ZERO;
      key2_reg <= `XCL_RST_ZERO;
    end else if (host_req.wr) begin
      if (host_req.index == `XCL_IDX_KEY1) begin
        key1_reg <= host_req.wdata;
      end else if (host_req.index == `XCL_IDX_KEY2) begin
        key2_reg <= host_req.wdata;
      end
    end
  end

  // extended set, gated by the first key
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      misc1_reg    <= `XCL_RST_ZERO;
      xfer_pos_reg <= `XCL_RST_ZERO;
      ilace_reg    <= `XCL_RST_ZERO;
    end else if (host_req.wr && ext_unlocked) begin // RQ23
      if (host_req.index == `XCL_IDX_MISC1) begin
        misc1_reg <= host_req.wdata & `XCL_MISC1_WMASK; // RQ5
      end else if (host_req.index == `XCL_IDX_XFER_POS) begin
        xfer_pos_reg <= host_req.wdata;
      end else if (host_req.index == `XCL_IDX_ILACE) begin
        ilace_reg <= host_req.wdata;
      end
    end
  end

  // system control set, gated by the second key
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      syscfg_reg  <= `XCL_RST_SYSCFG; // RQ3 RQ14 RQ15
      fwflag_reg  <= `XCL_RST_ZERO;
      pclk_reg    <= `XCL_RST_ZERO;
      extmode_reg <= `XCL_RST_ZERO;
    end else if (host_req.wr && sys_unlocked) begin // RQ3 RQ23
      if (host_req.index == `XCL_IDX_SYSCFG) begin
        syscfg_reg <= host_req.wdata;
      end else if (host_req.index == `XCL_IDX_FWFLAG) begin
        fwflag_reg <= host_req.wdata;
      end else if (host_req.index == `XCL_IDX_PCLK) begin
        pclk_reg <= host_req.wdata & `XCL_PCLK_WMASK; // RQ5
      end else if (host_req.index == `XCL_IDX_EXTMODE) begin
        extmode_reg <= host_req.wdata & `XCL_EXTMODE_WMASK; // RQ5
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path; locked or unmapped indices answer zero

  always_comb begin
    rdata_next = `XCL_RST_ZERO;
    if (host_req.index == `XCL_IDX_KEY1) begin
      rdata_next = key1_reg;
    end else if (host_req.index == `XCL_IDX_KEY2) begin
      rdata_next = key2_reg;
    end else if (host_req.index == `XCL_IDX_MISC1 && ext_unlocked) begin // RQ23
      rdata_next = misc1_reg;
    end else if (host_req.index == `XCL_IDX_XFER_POS && ext_unlocked) begin
      rdata_next = xfer_pos_reg;
    end else if (host_req.index == `XCL_IDX_ILACE && ext_unlocked) begin
      rdata_next = ilace_reg;
    end else if (host_req.index == `XCL_IDX_SYSCFG && sys_unlocked) begin // RQ3
      rdata_next = syscfg_reg;
    end else if (host_req.index == `XCL_IDX_FWFLAG && sys_unlocked) begin
      rdata_next = fwflag_reg;
    end else if (host_req.index == `XCL_IDX_PCLK && sys_unlocked) begin
      rdata_next = pclk_reg;
    end else if (host_req.index == `XCL_IDX_EXTMODE && sys_unlocked) begin
      rdata_next = extmode_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      host_rdata  <= `XCL_RST_ZERO;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_req.rd;
      if (host_req.rd) begin
        host_rdata <= rdata_next;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock synthesizer strobe: data set up, one-cycle strobe, hold

  always_comb begin
    stb_next = stb_reg;
    case (stb_reg)
      XCL_STB_IDLE: begin
        if (pclk_written_reg && pclk_use) begin
          stb_next = XCL_STB_SETUP;
        end
      end
      XCL_STB_SETUP: begin
        stb_next = XCL_STB_PULSE;
      end
      XCL_STB_PULSE: begin
        stb_next = XCL_STB_HOLD;
      end
      default: begin
        stb_next = XCL_STB_IDLE;
      end
    endcase
  end

  // a write arriving during a strobe stays pending and triggers another
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pclk_written_reg <= 1'b0;
    end else if (host_req.wr && sys_unlocked && host_req.index == `XCL_IDX_PCLK) begin
      pclk_written_reg <= 1'b1;
    end else if (stb_reg == XCL_STB_IDLE && pclk_use) begin
      pclk_written_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stb_reg            <= XCL_STB_IDLE;
      clock_strobe_write <= 1'b0;
      pixel_clock_select <= 4'h0;
    end else begin
      stb_reg            <= stb_next;
      clock_strobe_write <= (stb_next == XCL_STB_PULSE); // RQ18
      if (stb_next == XCL_STB_SETUP) begin
        pixel_clock_select <= pclk_reg[3:0]; // RQ18
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoded controls, all registered

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      refresh_count             <= 2'h0;
      top_memory_force          <= 1'b0;
      wide_color_shift_mode     <= 1'b0;
      high_speed_font_write     <= 1'b0;
      wide_memory_select_signal <= 1'b0;
      xfer_position_valid       <= 1'b0;
      xfer_position             <= `XCL_RST_ZERO;
      interlace_offset          <= `XCL_RST_ZERO;
      interlace_enable          <= 1'b0;
    end else begin
      // disabled alternate count falls back to count 0
      refresh_count             <= misc1_reg[2] ? misc1_reg[1:0] : 2'h0; // RQ6
      top_memory_force          <= misc1_reg[3]; // RQ7
      wide_color_shift_mode     <= misc1_reg[4]; // RQ8
      high_speed_font_write     <= misc1_reg[5];
      wide_memory_select_signal <= misc1_reg[7]; // RQ9
      xfer_position_valid       <= vram_config && compat_xfer_enable; // RQ10
      xfer_position             <= xfer_pos_reg; // RQ10
      interlace_enable          <= pclk_reg[5]; // RQ11
      interlace_offset          <= pclk_reg[5] ? ilace_reg : `XCL_RST_ZERO; // RQ11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enhanced_access_enable <= 1'b0;
      memory_id_pin_a        <= 1'b0;
      memory_id_pin_b        <= 1'b0;
      read_strobe_out        <= 1'b0;
      bus_request_out        <= 1'b0;
      bus_grant_seen         <= 1'b0;
      wait_states            <= `XCL_RST_WAIT_ONE;
      write_posting_enable   <= 1'b0;
      decode_wait_count      <= `XCL_RST_WAIT_CNT;
      read_wait_count        <= `XCL_RST_WAIT_CNT;
      zero_wait_signal       <= 1'b0;
    end else begin
      enhanced_access_enable <= syscfg.enhanced_access_enable; // RQ12
      // pins report their role: id active, strobe, or grant/request pair
      memory_id_pin_a <= !syscfg.memory_id_pin_select; // RQ13
      memory_id_pin_b <= !syscfg.memory_id_pin_select; // RQ13
      read_strobe_out <= syscfg.memory_id_pin_select && dac_ctrl_strobe_mode; // RQ13
      bus_request_out <= syscfg.memory_id_pin_select && !dac_ctrl_strobe_mode; // RQ13
      bus_grant_seen  <= syscfg.memory_id_pin_select && !dac_ctrl_strobe_mode
                         && bus_grant_in; // RQ13
      wait_states          <= {1'b0, syscfg.wait_insert_bit}; // RQ14
      write_posting_enable <= syscfg.write_posting_enable; // RQ15
      decode_wait_count    <= wait_decode(syscfg.decode_wait_field); // RQ16
      read_wait_count      <= wait_decode(syscfg.read_wait_field); // RQ17
      zero_wait_signal     <= isa_bus_mode && (syscfg.read_wait_field == 2'h0); // RQ17
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      video_clock_edge_mode     <= 1'b0;
      dac_select_ext_bit        <= 1'b0;
      screen_width_bit_eight    <= 1'b0;
      sixteen_bit_color_enable  <= 1'b0;
      extended_port_addr        <= `XCL_PORT_BASE;
      horizontal_counter_double <= 1'b0;
    end else begin
      video_clock_edge_mode     <= extmode_reg[0]; // RQ19
      dac_select_ext_bit        <= extmode_reg[1] && (dac_ctrl_select == 2'h0); // RQ20
      screen_width_bit_eight    <= extmode_reg[2] && (sys_ctrl2_width == 2'h0); // RQ21
      sixteen_bit_color_enable  <= extmode_reg[3];
      // only the low 12 bits are given; the high nibble is masked to zero
      extended_port_addr        <= extmode_reg[4] ?
                                   ((`XCL_PORT_BASE ^ `XCL_PORT_XOR) & `XCL_PORT_LOW_MASK) :
                                   `XCL_PORT_BASE; // RQ22
      horizontal_counter_double <= extmode_reg[7];
    end
  end

endmodule

// file: shared/xcl_cfg.svh
`ifndef XCL_CFG_SVH
`define XCL_CFG_SVH

// register indices on the index/data port
`define XCL_IDX_KEY1      8'h38
`define XCL_IDX_KEY2      8'h39
`define XCL_IDX_MISC1     8'h3a
`define XCL_IDX_XFER_POS  8'h3b
`define XCL_IDX_ILACE     8'h3c
`define XCL_IDX_SYSCFG    8'h40
`define XCL_IDX_FWFLAG    8'h41
`define XCL_IDX_PCLK      8'h42
`define XCL_IDX_EXTMODE   8'h43

// unlock key masks and values
`define XCL_KEY1_MASK     8'hcc
`define XCL_KEY1_VAL      8'h48
`define XCL_KEY2_MASK     8'he0
`define XCL_KEY2_VAL      8'ha0

// reset values
`define XCL_RST_ZERO      8'h00
`define XCL_RST_SYSCFG    8'ha4
`define XCL_RST_WAIT_ONE  2'h1
`define XCL_RST_WAIT_CNT  2'h3

// writable bit masks (reserved bits held at zero)
`define XCL_MISC1_WMASK   8'hbf
`define XCL_PCLK_WMASK    8'h2f
`define XCL_EXTMODE_WMASK 8'h9f

// port translation
`define XCL_PORT_BASE     16'h02e8
`define XCL_PORT_XOR      16'h03a0
`define XCL_PORT_LOW_MASK 16'h0fff

// clock select value that lets the pixel clock field drive the synthesizer
`define XCL_MISC_CLK_EXT  2'h3

`endif

// file: shared/xcl_pkg.sv
package xcl_pkg;

  // decoded settings from the system configuration register
  typedef struct packed {
    logic [1:0] read_wait_field;
    logic [1:0] decode_wait_field;
    logic       write_posting_enable;
    logic       wait_insert_bit;
    logic       memory_id_pin_select;
    logic       enhanced_access_enable;
  } xcl_syscfg_s;

  // host register port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] index;
    logic [7:0] wdata;
  } xcl_req_s;

  // strobe sequencer for the clock synthesizer load
  typedef enum logic [1:0] {
    XCL_STB_IDLE  = 2'b00,
    XCL_STB_SETUP = 2'b01,
    XCL_STB_PULSE = 2'b11,
    XCL_STB_HOLD  = 2'b10
  } xcl_stb_e;

endpackage

// file: tb/xcl_ext_ctrl_props.sv
`timescale 1ns/1ps
module xcl_ext_ctrl_props
  import xcl_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // host port
  input wire xcl_req_s   host_req,
  input wire logic       host_rvalid,
  // context and decoded controls
  input wire logic       isa_bus_mode,
  input wire logic [1:0] misc_clock_select,
  input wire logic       dac_ctrl_strobe_mode,
  input wire logic       read_strobe_out,
  input wire logic       bus_request_out,
  input wire logic       zero_wait_signal,
  input wire logic [1:0] read_wait_count,
  input wire logic       clock_strobe_write
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_read_answer_next: assert property (host_req.rd |=> host_rvalid)
    else $error("read not answered next cycle");
  a_valid_needs_read: assert property (host_rvalid |-> $past(host_req.rd))
    else $error("read valid without a read");
  a_strobe_one_cycle: assert property (clock_strobe_write |=> !clock_strobe_write)
    else $error("clock strobe longer than one cycle");
  a_strobe_clock_sel: assert property (clock_strobe_write |-> misc_clock_select == 2'h3)
    else $error("clock strobe with another clock select");
  a_zero_wait_signal_isa_only: assert property (zero_wait_signal |-> $past(isa_bus_mode))
    else $error("zero wait signal outside isa mode");
  a_zero_wait_signal_field_zero: assert property (zero_wait_signal |-> read_wait_count == 2'h0)
    else $error("zero wait signal with nonzero read wait");
  a_strobe_pin_mode: assert property (read_strobe_out |-> $past(dac_ctrl_strobe_mode)
    && !bus_request_out) else $error("read strobe in request mode");
  a_request_pin_mode: assert property (bus_request_out |-> !$past(dac_ctrl_strobe_mode)
    && !read_strobe_out) else $error("bus request in strobe mode");

  c_strobe: cover property (clock_strobe_write);
  c_zero_wait_signal: cover property (zero_wait_signal);
  c_read_strobe: cover property (read_strobe_out);
  c_bus_request: cover property (bus_request_out);
endmodule

bind xcl_ext_ctrl xcl_ext_ctrl_props xcl_ext_ctrl_props_inst (.sys_clk, .srst, .host_req,
  .host_rvalid, .isa_bus_mode, .misc_clock_select, .dac_ctrl_strobe_mode, .read_strobe_out,
  .bus_request_out, .zero_wait_signal, .read_wait_count, .clock_strobe_write);

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "xcl_cfg.svh"
module tb_top
  import xcl_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  xcl_req_s    host_req = '0;
  logic        isa_bus_mode = 1'b1, compat_xfer_enable = 1'b0, vram_config = 1'b1;
  logic        dac_ctrl_strobe_mode = 1'b0, bus_grant_in = 1'b1;
  logic [1:0]  misc_clock_select = 2'h0, dac_ctrl_select = 2'h0, sys_ctrl2_width = 2'h0;
  logic [7:0]  host_rdata, xfer_position, interlace_offset;
  logic [1:0]  refresh_count, wait_states, decode_wait_count, read_wait_count;
  logic [3:0]  pixel_clock_select;
  logic [15:0] extended_port_addr;
  logic        host_rvalid, top_memory_force, wide_color_shift_mode, high_speed_font_write;
  logic        wide_memory_select_signal, xfer_position_valid, interlace_enable;
  logic        enhanced_access_enable, memory_id_pin_a, memory_id_pin_b, read_strobe_out;
  logic        bus_request_out, bus_grant_seen, write_posting_enable, zero_wait_signal;
  logic        clock_strobe_write, video_clock_edge_mode, dac_select_ext_bit;
  logic        screen_width_bit_eight, sixteen_bit_color_enable, horizontal_counter_double;
  int          fail_count = 0;
  int          compares = 0;

  always #5 sys_clk = ~sys_clk;

  xcl_ext_ctrl xcl_ext_ctrl_inst (.sys_clk, .srst, .host_req, .host_rdata, .host_rvalid,
    .isa_bus_mode, .compat_xfer_enable, .vram_config, .misc_clock_select, .dac_ctrl_select,
    .dac_ctrl_strobe_mode, .sys_ctrl2_width, .bus_grant_in, .refresh_count, .top_memory_force,
    .wide_color_shift_mode, .high_speed_font_write, .wide_memory_select_signal,
    .xfer_position_valid, .xfer_position, .interlace_offset, .interlace_enable,
    .enhanced_access_enable, .memory_id_pin_a, .memory_id_pin_b, .read_strobe_out,
    .bus_request_out, .bus_grant_seen, .wait_states, .write_posting_enable,
    .decode_wait_count, .read_wait_count, .zero_wait_signal, .pixel_clock_select,
    .clock_strobe_write, .video_clock_edge_mode, .dac_select_ext_bit, .screen_width_bit_eight,
    .sixteen_bit_color_enable, .extended_port_addr, .horizontal_counter_double);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // requests are left standing so the next task can follow back to back
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host_req = '{rd: 1'b0, wr: 1'b1, index: idx, wdata: d};
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    host_req = '{rd: 1'b1, wr: 1'b0, index: idx, wdata: 8'h00};
    @(negedge sys_clk);
    chk(host_rvalid, 16'h1);
    chk(host_rdata, exp);
  endtask

  // decoded outputs lag the register by a cycle, so two idle cycles settle them
  task automatic idle(input int n);
    host_req = '0;
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic unlock();
    wr(`XCL_IDX_KEY1, 8'h7b);
    wr(`XCL_IDX_KEY2, 8'hbf);
    idle(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`XCL_IDX_KEY1, 8'h00);
    rd(`XCL_IDX_SYSCFG, 8'h00);
    wr(`XCL_IDX_SYSCFG, 8'h00);
    wr(`XCL_IDX_MISC1, 8'hff);
    wr(`XCL_IDX_KEY2, 8'h80);
    rd(`XCL_IDX_SYSCFG, 8'h00);
    idle(2);
    chk(wait_states, 16'h1);
    chk(decode_wait_count, 16'h3);
    chk(read_wait_count, 16'h3);
    chk(write_posting_enable, 16'h0);
    chk(wide_memory_select_signal, 16'h0);
    unlock();
    rd(`XCL_IDX_SYSCFG, 8'ha4);
    rd(`XCL_IDX_MISC1, 8'h00);
  endtask

  task automatic t_misc();
    wr(`XCL_IDX_MISC1, 8'hff);
    rd(`XCL_IDX_MISC1, 8'hbf);
    idle(2);
    chk(top_memory_force, 16'h1);
    chk(wide_color_shift_mode, 16'h1);
    chk(wide_memory_select_signal, 16'h1);
    chk(high_speed_font_write, 16'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`XCL_IDX_MISC1, 8'h04 | i[7:0]);
      idle(2);
      chk(refresh_count, i[1:0]);
    end
    wr(`XCL_IDX_MISC1, 8'h02);
    idle(2);
    chk(refresh_count, 16'h0);
    chk(wide_color_shift_mode, 16'h0);
    chk(high_speed_font_write, 16'h0);
  endtask

  task automatic t_waits();
    logic [1:0] map [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    for (int f = 0; f < 4; f++) begin
      wr(`XCL_IDX_SYSCFG, {f[1:0], f[1:0], 4'h9});
      idle(2);
      chk(decode_wait_count, map[f]);
      chk(read_wait_count, map[f]);
      chk(zero_wait_signal, f == 0);
      chk(enhanced_access_enable, 16'h1);
      chk(wait_states, 16'h0);
      chk(write_posting_enable, 16'h1);
    end
    isa_bus_mode = 1'b0;
    wr(`XCL_IDX_SYSCFG, 8'h00);
    idle(2);
    chk(zero_wait_signal, 16'h0);
    chk(enhanced_access_enable, 16'h0);
    isa_bus_mode = 1'b1;
  endtask

  task automatic t_pins();
    for (int m = 0; m < 2; m++) begin
      dac_ctrl_strobe_mode = m[0];
      wr(`XCL_IDX_SYSCFG, 8'h02);
      idle(2);
      chk(read_strobe_out, m == 1);
      chk(bus_request_out, m == 0);
      chk(bus_grant_seen, m == 0);
    end
    // grant pin low must not be reported as seen
    dac_ctrl_strobe_mode = 1'b0;
    bus_grant_in = 1'b0;
    idle(2);
    chk(bus_grant_seen, 16'h0);
    chk(bus_request_out, 16'h1);
    bus_grant_in = 1'b1;
    wr(`XCL_IDX_SYSCFG, 8'h00);
    idle(2);
    chk({memory_id_pin_a, memory_id_pin_b, read_strobe_out, bus_request_out}, 16'hc);
  endtask

  task automatic t_relock();
    wr(`XCL_IDX_KEY2, 8'ha0);
    idle(1);
    wr(`XCL_IDX_SYSCFG, 8'h00);
    wr(`XCL_IDX_KEY2, 8'he0);
    idle(1);
    wr(`XCL_IDX_SYSCFG, 8'hff);
    wr(`XCL_IDX_KEY1, 8'h4c);
    idle(1);
    rd(`XCL_IDX_MISC1, 8'h00);
    unlock();
    rd(`XCL_IDX_SYSCFG, 8'h00);
    rd(`XCL_IDX_MISC1, 8'h02);
  endtask

  task automatic t_pclk();
    int n = 0;
    wr(`XCL_IDX_PCLK, 8'hff);
    rd(`XCL_IDX_PCLK, 8'h2f);
    idle(8);
    chk(pixel_clock_select, 16'h0);
    chk(clock_strobe_write, 16'h0);
    chk(interlace_enable, 16'h1);
    misc_clock_select = 2'h3;
    while (clock_strobe_write !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        report_and_stop();
      end
      @(negedge sys_clk);
    end
    chk(pixel_clock_select, 16'hf);
    wr(`XCL_IDX_ILACE, 8'h5a);
    idle(2);
    chk(interlace_offset, 16'h5a);
    wr(`XCL_IDX_PCLK, 8'h00);
    idle(2);
    chk(interlace_offset, 16'h00);
    chk(interlace_enable, 16'h0);
  endtask

  task automatic t_ext();
    for (int s = 0; s < 2; s++) begin
      dac_ctrl_select = {1'b0, s[0]};
      sys_ctrl2_width = {s[0], 1'b0};
      wr(`XCL_IDX_EXTMODE, 8'hff);
      idle(2);
      chk(dac_select_ext_bit, s == 0);
      chk(screen_width_bit_eight, s == 0);
    end
    rd(`XCL_IDX_EXTMODE, 8'h9f);
    chk({video_clock_edge_mode, sixteen_bit_color_enable, horizontal_counter_double}, 16'h7);
    chk(extended_port_addr, 16'h0148);
    wr(`XCL_IDX_EXTMODE, 8'h00);
    wr(`XCL_IDX_XFER_POS, 8'ha5);
    compat_xfer_enable = 1'b1;
    idle(2);
    chk({video_clock_edge_mode, sixteen_bit_color_enable, horizontal_counter_double}, 16'h0);
    chk(extended_port_addr, 16'h02e8);
    chk({xfer_position_valid, xfer_position}, 16'h1a5);
    compat_xfer_enable = 1'b0;
    idle(2);
    chk(xfer_position_valid, 16'h0);
    // compatibility bit alone is not enough without a vram board
    vram_config = 1'b0;
    compat_xfer_enable = 1'b1;
    idle(2);
    chk(xfer_position_valid, 16'h0);
    compat_xfer_enable = 1'b0;
    vram_config = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    t_reset();
    t_misc();
    t_waits();
    t_pins();
    t_relock();
    t_pclk();
    t_ext();
    report_and_stop();
  end
endmodule
